// File: rtl/nand_boot_pkg.sv
package nand_boot_pkg;
  // Page geometry of the small-page part, x8 bus
  localparam int PAGE_BYTES = 528;
  localparam int MARK_IDX = 517;
  localparam int MARK_PAGES = 2;
  localparam int PAGES_PER_BLOCK = 32;
  localparam int TOTAL_PAGES = 65536;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam int FAIL_BIT = 0;
  // Timing and buffer sizing
  localparam int CLK_MHZ = 50;
  localparam int PROG_MAX_US = 500;
  localparam int ERASE_MAX_MS = 3;
  localparam int PROG_MAX_CYC = PROG_MAX_US * CLK_MHZ;
  localparam int ERASE_MAX_CYC = ERASE_MAX_MS * 1000 * CLK_MHZ;
  localparam int STEP_DIV = 2;
  localparam int SETTLE_CYC = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int BYTE_W = 8;
endpackage

// File: rtl/nand_boot_page_autoread.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
module boot_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic do_wr, do_rd;

  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];

  always_comb begin
    do_wr = in_valid_i && in_ready_o;
    do_rd = out_valid_o && out_ready_i;
    next_wr_ptr = do_wr ? AW'((32'(wr_ptr) + 1) % DEPTH) : wr_ptr;
    next_rd_ptr = do_rd ? AW'((32'(rd_ptr) + 1) % DEPTH) : rd_ptr;
    next_count = count;
    if (do_wr && !do_rd) begin
      next_count = count + 1'b1;
    end else if (do_rd && !do_wr) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage needs no reset; empty flag hides stale words
  always_ff @(posedge mclk_i) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////
module nand_boot_page_autoread #(
  parameter int BUSY_TIMEOUT = nand_boot_pkg::ERASE_MAX_CYC,
  parameter int PAGE_BYTES = nand_boot_pkg::PAGE_BYTES,
  parameter int TOTAL_PAGES = nand_boot_pkg::TOTAL_PAGES,
  parameter int FIFO_DEPTH = nand_boot_pkg::FIFO_DEPTH
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic seq_read_en_i,
  input wire logic stop_i,
  input wire logic status_req_i,
  output logic [7:0] data_o,
  output logic data_valid_o,
  input wire logic data_ready_i,
  output logic bad_block_o,
  output logic [10:0] bad_block_idx_o,
  output logic [11:0] bad_count_o,
  output logic status_valid_o,
  output logic grown_bad_o,
  output logic busy_timeout_o,
  output logic boot_done_o,
  output logic ce_n_o,
  output logic re_n_o,
  output logic we_n_o,
  output logic cle_o,
  output logic ale_o,
  output logic [7:0] io_o,
  output logic io_oe_o,
  input wire logic [7:0] io_i,
  input wire logic rb_i
);
  typedef enum logic [3:0] {
    S_WAIT_RB, S_RE_LO, S_RE_HI, S_PUSH, S_PAGE_END, S_SETTLE,
    S_IDLE, S_CMD_SET, S_CMD_WE, S_ST_RE, S_ST_DONE
  } state_t;

  localparam int TMO_W = $clog2(BUSY_TIMEOUT + 1);
  localparam int PG_W = $clog2(TOTAL_PAGES);
  localparam int BY_W = $clog2(PAGE_BYTES);
  localparam int BLK_SH = $clog2(nand_boot_pkg::PAGES_PER_BLOCK);

  state_t state, next_state;
  logic [TMO_W-1:0] tmo, next_tmo;
  logic [PG_W-1:0] page, next_page;
  logic [BY_W-1:0] byte_idx, next_byte_idx;
  logic [2:0] settle, next_settle;
  logic [7:0] rd_byte, next_rd_byte;
  logic [4:0] pins, next_pins;
  logic reported, next_reported;
  logic bad_p, next_bad_p;
  logic [10:0] bad_idx, next_bad_idx;
  logic [11:0] bad_cnt, next_bad_cnt;
  logic st_p, next_st_p;
  logic grown, next_grown;
  logic tmo_f, next_tmo_f;
  logic done, next_done;
  logic step;
  logic [0:0] div;
  logic [0:0] next_div;
  logic push_ready;
  logic [4:0] off_in_blk;

  // Pin pattern {ce_n, re_n, we_n, cle, oe} for each state
  function automatic logic [4:0] pin_map(input state_t s);
    case (s)
      S_IDLE: pin_map = 5'b11100;
      S_RE_LO, S_ST_RE: pin_map = 5'b00100;
      S_CMD_SET: pin_map = 5'b01011;
      S_CMD_WE: pin_map = 5'b01111;
      default: pin_map = 5'b01100;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Strobe pacing: one enable per STEP_DIV clocks
  // Restart on each state change so every strobe phase gets full width
  always_comb begin
    next_div = div + 1'b1;
    if (step || next_state != state) begin
      next_div = '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      div <= '0;
    end else begin
      div <= next_div;
    end
  end
  assign step = (32'(div) == nand_boot_pkg::STEP_DIV - 1);
  assign off_in_blk = page[4:0];

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_tmo = tmo;
    next_page = page;
    next_byte_idx = byte_idx;
    next_settle = settle;
    next_rd_byte = rd_byte;
    next_reported = reported;
    next_bad_p = 1'b0;
    next_bad_idx = bad_idx;
    next_bad_cnt = bad_cnt;
    next_st_p = 1'b0;
    next_grown = grown;
    next_tmo_f = tmo_f;
    next_done = done;
    case (state)
      S_WAIT_RB: begin
        if (rb_i) begin
          next_tmo = '0;
          next_state = S_RE_LO;
        end else if (32'(tmo) == BUSY_TIMEOUT - 1) begin
          next_tmo_f = 1'b1;
          next_state = S_IDLE;
        end else begin
          next_tmo = tmo + 1'b1;
        end
      end
      S_RE_LO: begin
        if (step) begin
          next_rd_byte = io_i;
          next_state = S_RE_HI;
        end
      end
      S_RE_HI: begin
        if (step) begin
          next_state = S_PUSH;
        end
      end
      // Stall strobes while the FIFO is full
      S_PUSH: begin
        if (push_ready) begin
          if (32'(byte_idx) == nand_boot_pkg::MARK_IDX
              && off_in_blk < 5'(nand_boot_pkg::MARK_PAGES)
              && rd_byte != nand_boot_pkg::ERASED_BYTE && !reported) begin
            next_reported = 1'b1;
            next_bad_p = 1'b1;
            next_bad_idx = 11'(page >> BLK_SH);
            next_bad_cnt = bad_cnt + 1'b1;
          end
          if (32'(byte_idx) == PAGE_BYTES - 1) begin
            next_byte_idx = '0;
            next_state = S_PAGE_END;
          end else begin
            next_byte_idx = byte_idx + 1'b1;
            next_state = S_RE_LO;
          end
        end
      end
      S_PAGE_END: begin
        next_page = page + 1'b1;
        if (off_in_blk == 5'(nand_boot_pkg::PAGES_PER_BLOCK - 1)) begin
          next_reported = 1'b0;
        end
        if (!seq_read_en_i || 32'(page) == TOTAL_PAGES - 1) begin
          next_done = 1'b1;
          next_state = S_IDLE;
        end else begin
          next_settle = '0;
          next_state = S_SETTLE;
        end
      end
      // Give the device time to pull busy low
      S_SETTLE: begin
        if (32'(settle) == nand_boot_pkg::SETTLE_CYC - 1) begin
          next_state = S_WAIT_RB;
        end else begin
          next_settle = settle + 1'b1;
        end
      end
      S_IDLE: begin
        if (status_req_i) begin
          next_state = S_CMD_SET;
        end
      end
      S_CMD_SET: begin
        if (step) begin
          next_state = S_CMD_WE;
        end
      end
      S_CMD_WE: begin
        if (step) begin
          next_state = S_ST_RE;
        end
      end
      S_ST_RE: begin
        if (step) begin
          next_rd_byte = io_i;
          next_state = S_ST_DONE;
        end
      end
      S_ST_DONE: begin
        if (step) begin
          next_grown = rd_byte[nand_boot_pkg::FAIL_BIT];
          next_st_p = 1'b1;
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
    if (stop_i && state inside {S_WAIT_RB, S_RE_LO, S_RE_HI, S_SETTLE}) begin
      next_done = 1'b1;
      next_state = S_IDLE;
    end
    next_pins = pin_map(next_state);
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state <= S_WAIT_RB;
      tmo <= '0;
      page <= '0;
      byte_idx <= '0;
      settle <= '0;
      rd_byte <= '0;
      pins <= 5'b01100;
      reported <= 1'b0;
      bad_p <= 1'b0;
      bad_idx <= '0;
      bad_cnt <= '0;
      st_p <= 1'b0;
      grown <= 1'b0;
      tmo_f <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      tmo <= next_tmo;
      page <= next_page;
      byte_idx <= next_byte_idx;
      settle <= next_settle;
      rd_byte <= next_rd_byte;
      pins <= next_pins;
      reported <= next_reported;
      bad_p <= next_bad_p;
      bad_idx <= next_bad_idx;
      bad_cnt <= next_bad_cnt;
      st_p <= next_st_p;
      grown <= next_grown;
      tmo_f <= next_tmo_f;
      done <= next_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  boot_fifo #(
    .WIDTH(nand_boot_pkg::BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(state == S_PUSH),
    .in_ready_o(push_ready),
    .in_data_i(rd_byte),
    .out_valid_o(data_valid_o),
    .out_ready_i(data_ready_i),
    .out_data_o(data_o)
  );

  assign ce_n_o = pins[4];
  assign re_n_o = pins[3];
  assign we_n_o = pins[2];
  assign cle_o = pins[1];
  assign io_oe_o = pins[0];
  assign ale_o = 1'b0;
  assign io_o = nand_boot_pkg::CMD_READ_STATUS;
  assign bad_block_o = bad_p;
  assign bad_block_idx_o = bad_idx;
  assign bad_count_o = bad_cnt;
  assign status_valid_o = st_p;
  assign grown_bad_o = grown;
  assign busy_timeout_o = tmo_f;
  assign boot_done_o = done;
endmodule
`default_nettype wire

// File: sim/autoread_props.sv
`timescale 1ns/1ps
`default_nettype none
module autoread_props #(
  parameter int BUSY_TIMEOUT = 200
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic stop_i,
  input wire logic rb_i,
  input wire logic ce_n_o,
  input wire logic re_n_o,
  input wire logic we_n_o,
  input wire logic cle_o,
  input wire logic io_oe_o,
  input wire logic [7:0] io_o,
  input wire logic bad_block_o,
  input wire logic [11:0] bad_count_o,
  input wire logic busy_timeout_o,
  input wire logic boot_done_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // Margin covers push and settle before the wait starts
  int rb_low;
  int next_rb_low;
  always_comb begin
    next_rb_low = rb_i ? 0 : rb_low + 1;
  end
  always_ff @(posedge mclk_i) begin
    rb_low <= sys_rst_i ? 0 : next_rb_low;
  end
  sequence stop_held;
    stop_i [*8];
  endsequence
  sequence cmd_latch;
    !we_n_o ##1 we_n_o;
  endsequence
  a_re_needs_ce: assert property (!re_n_o |-> !ce_n_o)
    else $error("strobe without enable");
  a_re_after_ready: assert property ($fell(re_n_o) |-> rb_i && $past(rb_i))
    else $error("strobe while busy");
  a_re_low_width: assert property ($fell(re_n_o) |-> !re_n_o [*2])
    else $error("strobe too short");
  a_cmd_code: assert property (!we_n_o |->
    cle_o && io_oe_o && !ce_n_o && io_o == 8'h70)
    else $error("bad command cycle");
  a_status_read: assert property (cmd_latch |-> ##[1:8] !re_n_o)
    else $error("status not read");
  a_bad_count: assert property (bad_block_o |->
    bad_count_o == $past(bad_count_o) + 12'h001)
    else $error("bad count not stepped");
  a_stop_ends: assert property (stop_held |-> ce_n_o && boot_done_o)
    else $error("stop ignored");
  a_busy_bound: assert property (rb_low > BUSY_TIMEOUT + 16 |->
    busy_timeout_o)
    else $error("busy wait unbounded");
endmodule
bind nand_boot_page_autoread autoread_props #(.BUSY_TIMEOUT(BUSY_TIMEOUT))
  i_autoread_props (.mclk_i, .sys_rst_i, .stop_i, .rb_i, .ce_n_o, .re_n_o,
  .we_n_o, .cle_o, .io_oe_o, .io_o, .bad_block_o, .bad_count_o,
  .busy_timeout_o, .boot_done_o);
`default_nettype wire

// File: sim/nand_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model #(
  parameter int PAGE = 520,
  parameter int LOAD = 30
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic seq_i,
  input wire logic fail_i,
  input wire logic hang_i,
  input wire logic ce_n_i,
  input wire logic re_n_i,
  input wire logic we_n_i,
  input wire logic cle_i,
  output logic [7:0] io_o,
  output logic rb_o
);
  int ptr;
  int page;
  int busy;
  logic re_q;
  logic halt;
  logic stat;
  logic [7:0] last;
  logic [7:0] cur;
  // erased marker except one mark; fail keeps data
  function automatic logic [7:0] byte_at(int p, int i);
    if (i == 517)
      return (p == 1) ? 8'h00 : 8'hFF;
    return 8'(i + 3 * p);
  endfunction
  assign cur = stat ? {7'h70, fail_i} : byte_at(page, ptr);
  assign rb_o = (busy == 0) && !hang_i;
  // released bus shows inverse, not a held value
  assign io_o = (!ce_n_i && !re_n_i) ? cur : ~last;
  //////////////////////////////////////////////////////////////////////
  // power-up loads page 0 unasked
  always @(posedge mclk_i) begin
    re_q <= re_n_i;
    if (sys_rst_i) begin
      ptr <= 0;
      page <= 0;
      busy <= LOAD;
      halt <= 1'b0;
      stat <= 1'b0;
      last <= 8'h5A;
    end else begin
      if (busy > 0)
        busy <= busy - 1;
      // enable high or command ends stream
      if (ce_n_i)
        halt <= 1'b1;
      if (!we_n_i && cle_i) begin
        halt <= 1'b1;
        stat <= 1'b1;
      end
      // one byte per strobe, pages on
      if (!re_q && re_n_i && !ce_n_i) begin
        last <= cur;
        ptr <= (ptr == PAGE - 1) ? 0 : ptr + 1;
        if (ptr == PAGE - 1 && seq_i && !halt) begin
          page <= page + 1;
          busy <= LOAD;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/test_nand_boot_page_autoread.sv
`timescale 1ns/1ps
`default_nettype none
module test_nand_boot_page_autoread;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic seq = 1'b0, stop = 1'b0, req = 1'b0, ready = 1'b0;
  logic fail = 1'b0, hang = 1'b0;
  logic [7:0] data, host_io, dev_io, bus;
  logic valid, done, sv, grown, tmo, ce_n, re_n, we_n, cle, oe, rb;
  logic ale, bad_p;
  logic [10:0] bad_idx;
  logic [11:0] bad_cnt;
  int failures = 0;
  int n_compared = 0;
  int n_bad = 0;
  always #10 mclk_i = ~mclk_i;
  // Pulse counter for the bad block strobe
  always @(posedge mclk_i) begin
    if (bad_p === 1'b1)
      n_bad++;
  end
  // Bus level from whichever side drives it
  assign bus = oe ? host_io : dev_io;
  nand_boot_page_autoread #(.BUSY_TIMEOUT(200), .PAGE_BYTES(520),
    .TOTAL_PAGES(64), .FIFO_DEPTH(16)) i_nand_boot_page_autoread (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .seq_read_en_i(seq),
    .stop_i(stop), .status_req_i(req), .data_o(data),
    .data_valid_o(valid), .data_ready_i(ready), .bad_block_o(bad_p),
    .bad_block_idx_o(bad_idx), .bad_count_o(bad_cnt),
    .status_valid_o(sv), .grown_bad_o(grown), .busy_timeout_o(tmo),
    .boot_done_o(done), .ce_n_o(ce_n), .re_n_o(re_n), .we_n_o(we_n),
    .cle_o(cle), .ale_o(ale), .io_o(host_io), .io_oe_o(oe), .io_i(bus),
    .rb_i(rb));
  nand_dev_model i_nand_dev_model (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .seq_i(seq), .fail_i(fail), .hang_i(hang), .ce_n_i(ce_n),
    .re_n_i(re_n), .we_n_i(we_n), .cle_i(cle), .io_o(dev_io), .rb_o(rb));
  //////////////////////////////////////////////////////////////////////
  task automatic flag(input string m);
    failures++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic results();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic do_reset(input logic s, input logic h);
    sys_rst_i <= 1'b1;
    seq <= s;
    hang <= h;
    tick(20);
    sys_rst_i <= 1'b0;
  endtask
  function automatic logic [7:0] want(int p, int i);
    if (i == 517)
      return (p == 1) ? 8'h00 : 8'hFF;
    return 8'(i + 3 * p);
  endfunction
  // Pop outruns the reader, so each byte waits for valid
  task automatic pop_page(input int p);
    int t;
    for (int i = 0; i < 520; i++) begin
      t = 0;
      @(posedge mclk_i);
      while (valid !== 1'b1 && t < 300) begin
        @(posedge mclk_i);
        t++;
      end
      n_compared++;
      if (data !== want(p, i))
        flag("stream byte wrong");
      ready <= 1'b1;
      @(posedge mclk_i);
      ready <= 1'b0;
    end
  endtask
  task automatic boot_single();
    do_reset(1'b0, 1'b0);
    tick(400);
    n_compared++;
    if (valid !== 1'b1 || re_n !== 1'b1)
      flag("full buffer not held");
    pop_page(0);
    tick(200);
    n_compared++;
    if (valid !== 1'b0 || done !== 1'b1 || ce_n !== 1'b1)
      flag("ran past page 0");
    n_compared++;
    if (bad_cnt !== 12'h000 || n_bad != 0)
      flag("good block counted");
    n_compared++;
    if (ale !== 1'b0)
      flag("address latch moved");
  endtask
  task automatic boot_seq();
    do_reset(1'b1, 1'b0);
    pop_page(0);
    pop_page(1);
    tick(1);
    n_compared++;
    if (bad_cnt !== 12'h001 || bad_idx !== 11'h000 || n_bad != 1)
      flag("bad block missed");
    ready <= 1'b1;
    stop <= 1'b1;
    tick(40);
    n_compared++;
    if (ce_n !== 1'b1 || done !== 1'b1)
      flag("stop ignored");
    stop <= 1'b0;
    ready <= 1'b0;
  endtask
  task automatic status_check();
    int t;
    for (int f = 0; f < 2; f++) begin
      fail <= f[0];
      // One-cycle request: a held level would start a second read
      req <= 1'b1;
      tick(1);
      req <= 1'b0;
      t = 0;
      while (sv !== 1'b1 && t < 100) begin
        @(posedge mclk_i);
        t++;
      end
      tick(20);
      n_compared++;
      if (t >= 100 || grown !== f[0])
        flag("status flag lost");
    end
  endtask
  task automatic timeout_check();
    int t;
    do_reset(1'b0, 1'b1);
    t = 0;
    while (tmo !== 1'b1 && t < 400) begin
      @(posedge mclk_i);
      t++;
    end
    n_compared++;
    if (t < 200 || tmo !== 1'b1 || re_n !== 1'b1)
      flag("busy timeout wrong");
  endtask
  initial begin
    boot_single();
    boot_seq();
    status_check();
    timeout_check();
    results();
  end
  initial begin
    tick(60000);
    failures++;
    results();
  end
endmodule
`default_nettype wire
